// ### spi_eeprom_command_access.sv
/*
  command logic of a 512-byte serial eeprom behind a four-wire link:
  opcode decode, status access, array reads and page writes, write
  protection and the self-timed write cycle.
  assumes the link clock is much slower than clk_sys_in and is sampled.
*/
// Behaviour
// - status read opcode shifts the status byte out on the serial output
// - status read is answered at any time, even during a write cycle
// - status write ignored unless select went high after the set-latch
// - write-protect pin low refuses every nonvolatile write
// - nonvolatile writes need the write latch set
// - block-protected array regions never get written
// - array read is opcode then address; opcode bit 3 is the ninth bit
// - read streams bytes, incrementing address, wrapping to zero
// - select going high ends a read
// - array write ignored unless select went high after the set-latch
// - array write holds select low; 1 to 16 bytes in one page
// - page address wraps within the page, overwriting earlier bytes
// - write starts only if select rises right after a full data byte; a status write also starts with no data byte or with extra clocks after it
// - busy flag stays one until the internal write finishes
// - after power-up output floats; opcode only after select falls
// - power-up clears the write latch and the flag bit
// - reset output held asserted for the power-up reset period
// - decode the six eight-bit opcodes, msb first
// - status reads zeros, timeout bits, protect bits, latch, busy
// - protect code 01 top quarter, 10 top half, 11 all
// - latch cleared when a write cycle starts or when write-protect pin low
`timescale 1ns/10ps
module spi_eeprom_command_access
  import eeprom_cmd_pkg::*;
#(
  parameter int WRITE_CYCLES = WRITE_CYCLE_CYC,
  parameter int POWERUP_CYCLES = POWERUP_RESET_CYC
) (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic reset_in,
  // serial link
  input wire logic sel_n_in,
  input wire logic sck_in,
  input wire logic sdi_in,
  input wire logic write_protect_n_in,
  output logic sdo_out,
  output logic sdo_oe_out,
  // status
  output logic reset_hold_out,
  output logic [7:0] status_out
);
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_OPCODE = 5'b00010,
    ST_ADDR = 5'b00100,
    ST_DATA = 5'b01000,
    ST_SINK = 5'b10000
  } phase_t;
  typedef enum logic [2:0] {
    CMD_NONE = 3'h0,
    CMD_STAT_RD = 3'h1,
    CMD_STAT_WR = 3'h2,
    CMD_ARR_RD = 3'h3,
    CMD_ARR_WR = 3'h4
  } cmd_t;

  function automatic logic is_protected(input logic [1:0] code, input logic [8:0] addr);
    case (code)
      2'b01: is_protected = addr >= PROT_Q_BASE;
      2'b10: is_protected = addr >= PROT_H_BASE;
      2'b11: is_protected = 1'b1;
      default: is_protected = 1'b0;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisation
  logic [3:0] lvl;
  logic [3:0] rise;
  logic [3:0] fall;
  link_sync #(.W(4)) u_sync (
    .clk_sys_in(clk_sys_in),
    .reset_in(reset_in),
    .reset_val_in(4'h 9),
    .pin_in({write_protect_n_in, sdi_in, sck_in, sel_n_in}),
    .level_out(lvl),
    .rise_out(rise),
    .fall_out(fall)
  );
  logic sel_n;
  logic sel_fall;
  logic sel_rise;
  logic sck_rise;
  logic sck_fall;
  logic sdi;
  logic wp_n;
  assign sel_n = lvl[0];
  assign sel_fall = fall[0];
  assign sel_rise = rise[0];
  assign sck_rise = rise[1] & ~lvl[0];
  assign sck_fall = fall[1] & ~lvl[0];
  assign sdi = lvl[2];
  assign wp_n = lvl[3];

  ////////////////////////////////////////////////////////////////////////
  // frame, command and page buffer state
  phase_t phase;
  phase_t next_phase;
  cmd_t cmd;
  cmd_t next_cmd;
  logic [7:0] shift_in;
  logic [7:0] next_shift_in;
  logic [2:0] bit_cnt;
  logic [2:0] next_bit_cnt;
  logic [8:0] addr;
  logic [8:0] next_addr;
  logic [7:0] shift_out;
  logic [7:0] next_shift_out;
  logic load_pending;
  logic next_load_pending;
  logic byte_done;
  logic next_byte_done;
  logic fresh_latch;
  logic next_fresh_latch;
  logic latch;
  logic next_latch;
  logic [3:0] nv_bits;
  logic [3:0] next_nv_bits;
  logic [3:0] stat_pend;
  logic [3:0] next_stat_pend;
  logic [7:0] page_buf [0:15];
  logic [15:0] page_valid;
  logic [15:0] next_page_valid;
  logic [8:0] page_base;
  logic [8:0] next_page_base;
  logic buf_wr;
  logic [3:0] buf_idx;
  logic [31:0] busy_cnt;
  logic [31:0] next_busy_cnt;
  logic [4:0] flush_idx;
  logic [4:0] next_flush_idx;
  logic busy;
  logic [8:0] mem_rd_addr;
  logic [7:0] mem_rd_data;
  logic mem_wr;
  logic [8:0] mem_wr_addr;
  logic [7:0] status_byte;
  logic [7:0] byte_now;
  logic sdo;
  logic next_sdo;
  logic sdo_oe;
  logic next_sdo_oe;

  assign busy = busy_cnt != 32'h0;
  assign byte_now = {shift_in[6:0], sdi};
  assign status_byte = {2'b00, nv_bits, latch, busy};
  assign mem_rd_addr = next_addr;

  always_comb begin
    next_phase = phase;
    next_cmd = cmd;
    next_shift_in = shift_in;
    next_bit_cnt = bit_cnt;
    next_addr = addr;
    next_shift_out = shift_out;
    next_load_pending = 1'b0;
    next_byte_done = byte_done;
    next_fresh_latch = fresh_latch;
    next_latch = latch;
    next_nv_bits = nv_bits;
    next_stat_pend = stat_pend;
    next_page_valid = page_valid;
    next_page_base = page_base;
    next_busy_cnt = busy ? busy_cnt - 32'h1 : busy_cnt;
    next_flush_idx = flush_idx;
    next_sdo = sdo;
    next_sdo_oe = sdo_oe;
    buf_wr = 1'b0;
    buf_idx = addr[PAGE_W-1:0];
    if (load_pending) begin
      next_shift_out = mem_rd_data;
    end
    if (sel_fall) begin
      next_phase = ST_OPCODE;
      next_bit_cnt = 3'h0;
      next_cmd = CMD_NONE;
      next_byte_done = 1'b0;
      next_page_valid = 16'h0;
    end else if (sel_rise) begin
      next_phase = ST_IDLE;
      next_sdo_oe = 1'b0;
      if (next_bit_cnt == 3'h0 && byte_done && wp_n && latch && !busy) begin
        if (cmd == CMD_STAT_WR) begin
          next_nv_bits = stat_pend;
          next_busy_cnt = 32'(WRITE_CYCLES);
          next_latch = 1'b0;
        end else if (cmd == CMD_ARR_WR && page_valid != 16'h0) begin
          next_busy_cnt = 32'(WRITE_CYCLES);
          next_flush_idx = 5'h0;
          next_latch = 1'b0;
        end
      end
      if (!(cmd == CMD_ARR_WR && next_busy_cnt != 32'h0 && !busy)) begin
        next_page_valid = 16'h0;
      end
    end else if (sck_fall && sdo_oe) begin
      next_sdo = shift_out[7];
      next_shift_out = {shift_out[6:0], 1'b0};
    end else if (sck_rise && phase != ST_IDLE && phase != ST_SINK) begin
      next_shift_in = byte_now;
      next_bit_cnt = bit_cnt + 3'h1;
      next_byte_done = 1'b0;
      if (bit_cnt == 3'h7) begin
        next_byte_done = 1'b1;
        case (phase)
          ST_OPCODE: begin
            next_phase = ST_SINK;
            if (byte_now == OP_SET_LATCH) begin
              next_latch = wp_n;
              next_fresh_latch = 1'b1;
            end else if (byte_now == OP_CLR_LATCH) begin
              next_latch = 1'b0;
            end else if (byte_now == OP_STAT_RD) begin
              next_cmd = CMD_STAT_RD;
              next_shift_out = status_byte;
              next_sdo_oe = 1'b1;
            end else if (byte_now == OP_STAT_WR && !fresh_latch) begin
              next_cmd = CMD_STAT_WR;
              next_phase = ST_DATA;
            end else if ((byte_now & OP_ARR_MASK) == OP_ARR_RD) begin
              next_cmd = CMD_ARR_RD;
              next_addr[8] = byte_now[OP_ADDR_BIT];
              next_phase = ST_ADDR;
            end else if ((byte_now & OP_ARR_MASK) == OP_ARR_WR && !fresh_latch) begin
              next_cmd = CMD_ARR_WR;
              next_addr[8] = byte_now[OP_ADDR_BIT];
              next_phase = ST_ADDR;
            end
          end
          ST_ADDR: begin
            next_addr[7:0] = byte_now;
            next_byte_done = 1'b0;
            next_phase = ST_DATA;
            if (cmd == CMD_ARR_RD) begin
              next_load_pending = 1'b1;
              next_sdo_oe = 1'b1;
            end else begin
              next_page_base = {addr[8], byte_now[7:PAGE_W], 4'h0};
            end
          end
          ST_DATA: begin
            if (cmd == CMD_ARR_RD) begin
              next_addr = addr + 9'h1;
              next_load_pending = 1'b1;
              next_byte_done = 1'b0;
            end else if (cmd == CMD_STAT_WR) begin
              next_stat_pend = byte_now[ST_TMO_HI:ST_PROT_LO];
              next_phase = ST_SINK;
            end else begin
              buf_wr = !busy;
              next_page_valid[addr[PAGE_W-1:0]] = !busy;
              next_addr = {addr[8:PAGE_W], addr[PAGE_W-1:0] + 4'h1};
            end
          end
          default: begin
          end
        endcase
      end
    end
    if (!sel_n && sel_rise == 1'b0 && phase == ST_IDLE) begin
      next_fresh_latch = fresh_latch;
    end
    if (sel_rise) begin
      next_fresh_latch = 1'b0;
    end
    if (!wp_n) begin
      next_latch = 1'b0;
    end
    if (busy && flush_idx != 5'h10) begin
      next_flush_idx = flush_idx + 5'h1;
    end
  end

  // flush of the page buffer into the array while busy
  assign mem_wr_addr = page_base | {5'h0, flush_idx[3:0]};
  assign mem_wr = busy && flush_idx != 5'h10 && page_valid[flush_idx[3:0]] &&
                  !is_protected(nv_bits[1:0], mem_wr_addr);

  always_ff @(posedge clk_sys_in) begin
    if (buf_wr) begin
      page_buf[buf_idx] <= byte_now;
    end
  end

  eeprom_array_mem #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_mem (
    .clk_sys_in(clk_sys_in),
    .wr_en_in(mem_wr),
    .wr_addr_in(mem_wr_addr),
    .wr_data_in(page_buf[flush_idx[3:0]]),
    .rd_addr_in(mem_rd_addr),
    .rd_data_out(mem_rd_data)
  );

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      phase <= ST_IDLE;
      cmd <= CMD_NONE;
      shift_in <= 8'h00;
      bit_cnt <= 3'h0;
      addr <= 9'h000;
      shift_out <= 8'h00;
      load_pending <= 1'b0;
      byte_done <= 1'b0;
      fresh_latch <= 1'b0;
      latch <= 1'b0;
      nv_bits <= NV_BITS_RESET;
      stat_pend <= NV_BITS_RESET;
      page_valid <= 16'h0;
      page_base <= 9'h000;
      busy_cnt <= 32'h0;
      flush_idx <= 5'h10;
      sdo <= 1'b0;
      sdo_oe <= 1'b0;
    end else begin
      phase <= next_phase;
      cmd <= next_cmd;
      shift_in <= next_shift_in;
      bit_cnt <= next_bit_cnt;
      addr <= next_addr;
      shift_out <= next_shift_out;
      load_pending <= next_load_pending;
      byte_done <= next_byte_done;
      fresh_latch <= next_fresh_latch;
      latch <= next_latch;
      nv_bits <= next_nv_bits;
      stat_pend <= next_stat_pend;
      page_valid <= next_page_valid;
      page_base <= next_page_base;
      busy_cnt <= next_busy_cnt;
      flush_idx <= next_flush_idx;
      sdo <= next_sdo;
      sdo_oe <= next_sdo_oe;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // power-up reset output and registered status
  logic [31:0] por_cnt;
  logic [31:0] next_por_cnt;
  logic next_reset_hold;
  always_comb begin
    next_por_cnt = por_cnt;
    if (por_cnt != 32'h0) begin
      next_por_cnt = por_cnt - 32'h1;
    end
    next_reset_hold = por_cnt > 32'h1;
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      por_cnt <= 32'(POWERUP_CYCLES);
      reset_hold_out <= 1'b1;
      status_out <= STATUS_RESET;
    end else begin
      por_cnt <= next_por_cnt;
      reset_hold_out <= next_reset_hold;
      status_out <= status_byte;
    end
  end

  assign sdo_out = sdo;
  assign sdo_oe_out = sdo_oe;
endmodule // spi_eeprom_command_access

// ### eeprom_cmd_pkg.sv
/*
  constants for the serial eeprom command block: opcodes, status layout,
  protect map, page geometry and timing counts.
  assumes a 50 MHz system clock sampling the serial link.
*/
package eeprom_cmd_pkg;
  localparam int CLK_HZ = 50_000_000;
  localparam int ADDR_W = 9;
  localparam int DATA_W = 8;
  localparam int PAGE_W = 4;
  // opcodes, bit 3 of the array opcodes carries the upper address bit
  localparam logic [7:0] OP_SET_LATCH = 8'h06;
  localparam logic [7:0] OP_CLR_LATCH = 8'h04;
  localparam logic [7:0] OP_STAT_RD = 8'h05;
  localparam logic [7:0] OP_STAT_WR = 8'h01;
  localparam logic [7:0] OP_ARR_MASK = 8'hF7;
  localparam logic [7:0] OP_ARR_RD = 8'h03;
  localparam logic [7:0] OP_ARR_WR = 8'h02;
  localparam int OP_ADDR_BIT = 3;
  // status byte fields
  localparam int ST_BUSY = 0;
  localparam int ST_LATCH = 1;
  localparam int ST_PROT_LO = 2;
  localparam int ST_PROT_HI = 3;
  localparam int ST_TMO_LO = 4;
  localparam int ST_TMO_HI = 5;
  localparam logic [7:0] STATUS_RESET = 8'h30;
  localparam logic [3:0] NV_BITS_RESET = 4'h C;
  // protect region start addresses
  localparam logic [8:0] PROT_Q_BASE = 9'h180;
  localparam logic [8:0] PROT_H_BASE = 9'h100;
  // timing: write cycle and power-up reset
  localparam int WRITE_CYCLE_MS = 10;
  localparam int WRITE_CYCLE_CYC = CLK_HZ / 1000 * WRITE_CYCLE_MS;
  localparam int POWERUP_RESET_MS = 100;
  localparam int POWERUP_RESET_CYC = CLK_HZ / 1000 * POWERUP_RESET_MS;
endpackage

// ### eeprom_array_mem.sv
/*
  512 x 8 storage for the eeprom array, one write port and a registered
  read port. assumes the caller holds the write strobe for one cycle.
*/
`timescale 1ns/10ps
module eeprom_array_mem #(
  parameter int ADDR_W = 9,
  parameter int DATA_W = 8
) (
  // clock
  input wire logic clk_sys_in,
  // write port
  input wire logic wr_en_in,
  input wire logic [ADDR_W-1:0] wr_addr_in,
  input wire logic [DATA_W-1:0] wr_data_in,
  // read port
  input wire logic [ADDR_W-1:0] rd_addr_in,
  output logic [DATA_W-1:0] rd_data_out
);
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

  always_ff @(posedge clk_sys_in) begin
    if (wr_en_in) begin
      mem[wr_addr_in] <= wr_data_in;
    end
    rd_data_out <= mem[rd_addr_in];
  end
endmodule // eeprom_array_mem

// ### link_sync.sv
/*
  two-flop synchroniser for a bundle of link pins plus edge flags taken
  from the synchronised copy. assumes pins are asynchronous to clk_sys_in.
*/
`timescale 1ns/10ps
module link_sync #(
  parameter int W = 4
) (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic reset_in,
  input wire logic [W-1:0] reset_val_in,
  // pins
  input wire logic [W-1:0] pin_in,
  // synchronised levels and edges
  output logic [W-1:0] level_out,
  output logic [W-1:0] rise_out,
  output logic [W-1:0] fall_out
);
  logic [W-1:0] stage1;
  logic [W-1:0] stage2;
  logic [W-1:0] stage3;

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      stage1 <= reset_val_in;
      stage2 <= reset_val_in;
      stage3 <= reset_val_in;
    end else begin
      stage1 <= pin_in;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  assign level_out = stage2;
  assign rise_out = stage2 & ~stage3;
  assign fall_out = ~stage2 & stage3;
endmodule // link_sync

// ### eeprom_cmd_assertions.sv
/*
  assertions on the pins of the eeprom command block.
  assumes binding onto spi_eeprom_command_access.
*/
`timescale 1ns/10ps
module eeprom_cmd_assertions
  import eeprom_cmd_pkg::*;
#(
  parameter int WRITE_CYCLES = 40,
  parameter int POWERUP_CYCLES = 20
) (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic reset_in,
  // pins
  input wire logic sel_n_in,
  input wire logic sck_in,
  input wire logic write_protect_n_in,
  input wire logic sdo_out,
  input wire logic sdo_oe_out,
  input wire logic reset_hold_out,
  input wire logic [7:0] status_out
);
  int up_cnt;
  int busy_cnt;
  int next_up_cnt;
  int next_busy_cnt;
  always_comb begin
    next_up_cnt = (up_cnt > POWERUP_CYCLES + 8) ? up_cnt : up_cnt + 1;
    next_busy_cnt = status_out[ST_BUSY] ? busy_cnt + 1 : 0;
  end
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      up_cnt <= 0;
      busy_cnt <= 0;
    end else begin
      up_cnt <= next_up_cnt;
      busy_cnt <= next_busy_cnt;
    end
  end
  ////////////////////////////////////////
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (reset_in);
  hold_early_a: assert property (up_cnt < POWERUP_CYCLES - 1 |-> reset_hold_out)
    else $error("reset out dropped early");
  hold_late_a: assert property (up_cnt > POWERUP_CYCLES + 2 |-> !reset_hold_out)
    else $error("reset out held too long");
  reset_status_a: assert property ($fell(reset_in) |-> status_out == STATUS_RESET)
    else $error("status not at reset value");
  status_top_a: assert property (status_out[7:6] == 2'b00)
    else $error("status top bits set");
  wp_latch_a: assert property (!write_protect_n_in [*6] |-> !status_out[ST_LATCH])
    else $error("latch set with protect low");
  oe_idle_a: assert property (sel_n_in [*6] |-> !sdo_oe_out)
    else $error("output driven while deselected");
  busy_len_a: assert property ($fell(status_out[ST_BUSY]) |->
    busy_cnt >= WRITE_CYCLES - 2 && busy_cnt <= WRITE_CYCLES + 2)
    else $error("busy length wrong");
  busy_start_a: assert property ($rose(status_out[ST_BUSY]) |-> sel_n_in)
    else $error("write began inside a frame");
  busy_end_a: assert property ($fell(status_out[ST_BUSY]) |-> !status_out[ST_LATCH])
    else $error("latch kept after write");
  sdo_fall_a: assert property (sdo_oe_out && $changed(sdo_out) |-> !$past(sck_in, 2))
    else $error("output moved off the falling edge");
  latch_wp_a: assert property ($rose(status_out[ST_LATCH]) |-> $past(write_protect_n_in, 4))
    else $error("latch set while protected");
  cover property ($rose(status_out[ST_BUSY]));
  cover property ($rose(status_out[ST_LATCH]));
  cover property ($rose(sdo_oe_out));
endmodule // eeprom_cmd_assertions

bind spi_eeprom_command_access eeprom_cmd_assertions #(
  .WRITE_CYCLES(WRITE_CYCLES),
  .POWERUP_CYCLES(POWERUP_CYCLES)
) chk (
  .clk_sys_in(clk_sys_in),
  .reset_in(reset_in),
  .sel_n_in(sel_n_in),
  .sck_in(sck_in),
  .write_protect_n_in(write_protect_n_in),
  .sdo_out(sdo_out),
  .sdo_oe_out(sdo_oe_out),
  .reset_hold_out(reset_hold_out),
  .status_out(status_out)
);

// ### spi_host_model.sv
/*
  behavioural serial host, clock idle low, 160 ns bit time.
  assumes one caller of its tasks at a time, entered at a falling clk edge.
*/
`timescale 1ns/10ps
module spi_host_model (
  // clock
  input wire logic clk_sys_in,
  // link
  output logic sel_n_out,
  output logic sck_out,
  output logic sdi_out,
  input wire logic sdo_in,
  input wire logic sdo_oe_in
);
  logic [7:0] rx;
  initial begin
    sel_n_out = 1'b1;
    sck_out = 1'b0;
    sdi_out = 1'b0;
    rx = 8'h00;
  end
  task automatic wait_clk(input int n);
    repeat (n) @(negedge clk_sys_in);
  endtask
  task automatic open_frame();
    wait_clk(1);
    sel_n_out = 1'b0;
    wait_clk(4);
  endtask
  // released data line shows the inverse of its last bit
  task automatic close_frame();
    sel_n_out = 1'b1;
    sdi_out = ~sdi_out;
    wait_clk(8);
  endtask
  // msb first; data set while sck low, output sampled just before the fall
  task automatic xfer(input logic [7:0] tx, input int n);
    for (int i = 7; i > 7 - n; i--) begin
      sck_out = 1'b0;
      sdi_out = tx[i];
      wait_clk(4);
      sck_out = 1'b1;
      wait_clk(4);
      rx[i] = sdo_oe_in ? sdo_in : 1'bz;
    end
    sck_out = 1'b0;
    wait_clk(4);
  endtask
endmodule // spi_host_model

// ### testbench.sv
/*
  self-checking bench for the eeprom command block.
  assumes the host model drives the link pins and a checker is bound.
*/
`timescale 1ns/10ps
module testbench
  import eeprom_cmd_pkg::*;
();
  localparam int WC = 400;
  localparam int PU = 20;
  logic clk_sys_in = 1'b0;
  logic reset_in = 1'b1;
  logic wp_n = 1'b1;
  logic sel_n;
  logic sck;
  logic sdi;
  logic sdo;
  logic sdo_oe;
  logic reset_hold;
  logic [7:0] status;
  logic [7:0] mem [512];
  int errors = 0;
  int checks = 0;
  int cyc = 0;
  always #10 clk_sys_in = ~clk_sys_in;
  spi_host_model host (.clk_sys_in(clk_sys_in), .sel_n_out(sel_n), .sck_out(sck),
    .sdi_out(sdi), .sdo_in(sdo), .sdo_oe_in(sdo_oe));
  spi_eeprom_command_access #(.WRITE_CYCLES(WC), .POWERUP_CYCLES(PU)) dut (
    .clk_sys_in(clk_sys_in), .reset_in(reset_in), .sel_n_in(sel_n), .sck_in(sck),
    .sdi_in(sdi), .write_protect_n_in(wp_n), .sdo_out(sdo), .sdo_oe_out(sdo_oe),
    .reset_hold_out(reset_hold), .status_out(status));
  ////////////////////////////////////////
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge clk_sys_in) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      errors = errors + 1;
      complete_run();
    end
  end
  task automatic cmd(input logic [7:0] op);
    host.open_frame();
    host.xfer(op, 8);
    host.close_frame();
  endtask
  task automatic rd_status(input logic [7:0] mask, input logic [7:0] exp);
    host.open_frame();
    host.xfer(OP_STAT_RD, 8);
    host.xfer(8'h00, 8);
    host.close_frame();
    check(host.rx & mask, exp);
  endtask
  // page write; ok tells whether the bytes should land
  task automatic wr(input logic [8:0] a, input int n, input logic [7:0] v, input bit ok);
    logic [8:0] p;
    p = a;
    host.open_frame();
    host.xfer(OP_ARR_WR | {4'h0, a[8], 3'h0}, 8);
    host.xfer(a[7:0], 8);
    for (int i = 0; i < n; i++) begin
      host.xfer(v + 8'(i), 8);
      if (ok)
        mem[p] = v + 8'(i);
      p[3:0] = p[3:0] + 4'h1;
    end
    host.close_frame();
    host.wait_clk(WC + 8);
  endtask
  task automatic rd(input logic [8:0] a, input int n);
    host.open_frame();
    host.xfer(OP_ARR_RD | {4'h0, a[8], 3'h0}, 8);
    host.xfer(a[7:0], 8);
    for (int i = 0; i < n; i++) begin
      host.xfer(8'h00, 8);
      check(host.rx, mem[a + 9'(i)]);
    end
    host.close_frame();
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (16) @(negedge clk_sys_in);
    reset_in = 1'b0;
    check(8'(reset_hold), 8'h01);
    check(8'(sdo_oe), 8'h00);
    host.wait_clk(PU + 4);
    check(8'(reset_hold), 8'h00);
    rd_status(8'hFF, STATUS_RESET);
    cmd(OP_SET_LATCH);
    rd_status(8'hFF, 8'h32);
    cmd(OP_CLR_LATCH);
    rd_status(8'hFF, 8'h30);
    cmd(OP_SET_LATCH);
    wr(9'h1F8, 17, 8'h10, 1'b1);
    rd_status(8'hFF, 8'h30);
    for (int k = 0; k < 2; k++) begin
      cmd(OP_SET_LATCH);
      wr(9'(k * 256), 16, 8'h40 + 8'(k * 64), 1'b1);
    end
    rd(9'h1FE, 4);
    rd(9'h100, 2);
    wr(9'h000, 1, 8'hA5, 1'b0);
    wp_n = 1'b0;
    cmd(OP_SET_LATCH);
    wr(9'h001, 1, 8'hA5, 1'b0);
    wp_n = 1'b1;
    cmd(OP_SET_LATCH);
    wp_n = 1'b0;
    host.wait_clk(8);
    wp_n = 1'b1;
    rd_status(8'hFF, 8'h30);
    cmd(OP_SET_LATCH);
    host.open_frame();
    host.xfer(OP_ARR_WR, 8);
    host.xfer(8'h02, 8);
    host.xfer(8'h5A, 5);
    host.close_frame();
    host.wait_clk(WC + 8);
    host.open_frame();
    host.xfer(OP_SET_LATCH, 8);
    host.xfer(OP_ARR_WR, 8);
    host.xfer(8'h03, 8);
    host.xfer(8'h5A, 8);
    host.close_frame();
    host.wait_clk(WC + 8);
    cmd(OP_CLR_LATCH);
    rd(9'h000, 4);
    cmd(OP_SET_LATCH);
    host.open_frame();
    host.xfer(OP_STAT_WR, 8);
    host.xfer(8'h04, 8);
    host.close_frame();
    rd_status(8'h01, 8'h01);
    host.wait_clk(WC);
    rd_status(8'hFF, 8'h04);
    cmd(OP_SET_LATCH);
    wr(9'h1F0, 1, 8'hEE, 1'b0);
    cmd(OP_SET_LATCH);
    wr(9'h17F, 1, 8'h77, 1'b1);
    rd(9'h17F, 1);
    rd(9'h1F0, 1);
    complete_run();
  end
endmodule // testbench
